// file: logic/uif_map.svh
`ifndef UIF_MAP_SVH
`define UIF_MAP_SVH
// ==========================================================
// register byte addresses
`define UIF_ADDR_IN_FLAGS 16'hde02
`define UIF_ADDR_OUT_FLAGS 16'hde04
`define UIF_ADDR_COMMON_FLAGS 16'hde06
`define UIF_ADDR_IN_ENABLE 16'hde07
`define UIF_ADDR_OUT_ENABLE 16'hde09
`define UIF_ADDR_COMMON_ENABLE 16'hde0b
`define UIF_ADDR_FRAME_LOW 16'hde0c
`define UIF_ADDR_FRAME_HIGH 16'hde0d
`define UIF_ADDR_INDEX 16'hde0e
// ==========================================================
// common register bit positions
`define UIF_BIT_FRAME_START 3
`define UIF_BIT_BUS_RESET 2
`define UIF_BIT_BUS_RESUME 1
`define UIF_BIT_BUS_SUSPEND 0
// ==========================================================
// reset values
`define UIF_RST_IN_ENABLE 8'h3f
`define UIF_RST_OUT_ENABLE 8'h3e
`define UIF_RST_COMMON_ENABLE 4'h6
`define UIF_RST_INDEX 4'h0
// ==========================================================
// valid bit masks
`define UIF_MASK_IN_FLAGS 6'h3f
`define UIF_MASK_OUT_FLAGS 6'h3e
// ==========================================================
// timing
`define UIF_SUSPEND_IDLE_MS 3
`define UIF_CLOCK_KHZ 50000
`define UIF_SUSPEND_IDLE_CYCLES (`UIF_SUSPEND_IDLE_MS * `UIF_CLOCK_KHZ)
`endif

// file: logic/uif_pkg.sv
package uif_pkg;
  typedef logic [7:0] uif_byte_t;
  typedef logic [15:0] uif_addr_t;
  typedef logic [10:0] uif_frame_t;
  typedef logic [3:0] uif_index_t;
endpackage : uif_pkg

// file: logic/uif_interrupt_bank.sv
`timescale 1ns/1ps
`include "uif_map.svh"
// Overview of operation
// R1 - IN flag register: endpoint 0 at bit 0, IN endpoints 1-5 at bits 5:1, 7:6 zero.
// R2 - Every event flag clears when its register is read; all reset to zero.
// R3 - OUT flag register: OUT endpoints 1-5 at bits 5:1, bit 0 unused.
// R4 - Common flags: frame start bit 3, bus reset 2, resume 1, suspend 0.
// R5 - IN enable mask bits 5:0, one enables, all reset to one.
// R6 - Software writes zeros into bits 7:6 of both endpoint enable masks.
// R7 - OUT enable mask bits 5:1, one enables, reset to one; bit 0 unused.
// R8 - Common enables: frame start 0, bus reset 1, resume 1, suspend 0 at reset.
// R9 - Low eight frame number bits readable, reset zero.
// R10 - Frame number bits 10:8 readable in bits 2:0 of another register.
// R11 - Software writes only 0 to 5 into the four-bit endpoint index.
// R12 - Endpoint index selects which endpoint's indexed registers appear.
// R13 - Bus reset clears index and re-enables all but frame start and suspend.
// R14 - Suspend flag sets after 3 ms bus idle when suspend enable is one.
// R15 - Interrupt request is high while any flag and its enable are both set.
module uif_interrupt_bank #(
  parameter int unsigned IdleCycles = `UIF_SUSPEND_IDLE_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register access port
  input wire uif_pkg::uif_addr_t regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire uif_pkg::uif_byte_t regWdata,
  output uif_pkg::uif_byte_t regRdata,
  // events from the engine as one-cycle pulses, then frame number, bus idle and suspend enable as levels
  input wire logic [5:0] inEvent,
  input wire logic [5:1] outEvent,
  input wire logic frameStartEvent,
  input wire logic busResetEvent,
  input wire logic busResumeEvent,
  input wire uif_pkg::uif_frame_t frameNumber,
  input wire logic busIdle,
  input wire logic suspendEnable,
  // outputs
  output uif_pkg::uif_index_t endpointIndex,
  output logic usbIrq
);
  import uif_pkg::*;

  // ==========================================================
  // parameter check
  if (IdleCycles < 1) begin : g_badIdle
    $error("IdleCycles must be at least one");
  end

  // ==========================================================
  // state
  logic [5:0] inFlags_r, inFlags_nxt;
  logic [5:1] outFlags_r, outFlags_nxt;
  logic [3:0] comFlags_r, comFlags_nxt;
  logic [7:0] inEn_r, inEn_nxt;
  logic [7:1] outEn_r, outEn_nxt;
  logic [3:0] comEn_r, comEn_nxt;
  uif_frame_t frame_r, frame_nxt;
  uif_index_t index_r, index_nxt;
  uif_byte_t rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  logic [31:0] idleCnt_r, idleCnt_nxt;
  logic suspended_r, suspended_nxt;
  logic idleHit;

  function automatic logic hit(input uif_addr_t a, input uif_addr_t target);
    return a == target;
  endfunction : hit

  // ==========================================================
  // suspend detection on continuous idle
  always_comb begin
    idleCnt_nxt = idleCnt_r;
    suspended_nxt = suspended_r;
    idleHit = 1'b0;
    if (!busIdle || !suspendEnable) begin
      idleCnt_nxt = 32'h0;
      suspended_nxt = 1'b0;
    end else if (!suspended_r) begin
      // the counter parks once the flag fires, so it sets once per idle period
      if (idleCnt_r >= IdleCycles - 1) begin
        idleHit = 1'b1; // [R14]
        suspended_nxt = 1'b1;
      end else begin
        idleCnt_nxt = idleCnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      idleCnt_r <= 32'h0;
      suspended_r <= 1'b0;
    end else begin
      idleCnt_r <= idleCnt_nxt;
      suspended_r <= suspended_nxt;
    end
  end

  // ==========================================================
  // event flags
  always_comb begin
    inFlags_nxt = inFlags_r;
    outFlags_nxt = outFlags_r;
    comFlags_nxt = comFlags_r;
    if (regRead && hit(regAddr, `UIF_ADDR_IN_FLAGS)) begin
      inFlags_nxt = 6'h00; // [R2]
    end
    if (regRead && hit(regAddr, `UIF_ADDR_OUT_FLAGS)) begin
      outFlags_nxt = 5'h00; // [R2]
    end
    if (regRead && hit(regAddr, `UIF_ADDR_COMMON_FLAGS)) begin
      comFlags_nxt = 4'h0; // [R2]
    end
    // events applied after the clear, so a set in the read cycle is kept
    inFlags_nxt = inFlags_nxt | inEvent; // [R1]
    outFlags_nxt = outFlags_nxt | outEvent; // [R3]
    comFlags_nxt[`UIF_BIT_FRAME_START] = comFlags_nxt[`UIF_BIT_FRAME_START] | frameStartEvent; // [R4]
    comFlags_nxt[`UIF_BIT_BUS_RESET] = comFlags_nxt[`UIF_BIT_BUS_RESET] | busResetEvent; // [R4]
    comFlags_nxt[`UIF_BIT_BUS_RESUME] = comFlags_nxt[`UIF_BIT_BUS_RESUME] | busResumeEvent; // [R4]
    comFlags_nxt[`UIF_BIT_BUS_SUSPEND] = comFlags_nxt[`UIF_BIT_BUS_SUSPEND] | idleHit; // [R14]
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      inFlags_r <= 6'h00; // [R2]
      outFlags_r <= 5'h00; // [R2]
      comFlags_r <= 4'h0; // [R2]
    end else begin
      inFlags_r <= inFlags_nxt;
      outFlags_r <= outFlags_nxt;
      comFlags_r <= comFlags_nxt;
    end
  end

  // ==========================================================
  // enable masks and endpoint index
  always_comb begin
    inEn_nxt = inEn_r;
    outEn_nxt = outEn_r;
    comEn_nxt = comEn_r;
    index_nxt = index_r;
    if (regWrite) begin
      // reserved bits 7:6 of the endpoint masks are stored as written
      if (hit(regAddr, `UIF_ADDR_IN_ENABLE)) begin
        inEn_nxt = regWdata; // [R5] [R6]
      end
      if (hit(regAddr, `UIF_ADDR_OUT_ENABLE)) begin
        outEn_nxt = regWdata[7:1]; // [R7] [R6]
      end
      if (hit(regAddr, `UIF_ADDR_COMMON_ENABLE)) begin
        comEn_nxt = regWdata[3:0]; // [R8]
      end
      if (hit(regAddr, `UIF_ADDR_INDEX)) begin
        index_nxt = regWdata[3:0]; // [R11] [R12]
      end
    end
    // bus reset wins over a same-cycle write
    if (busResetEvent) begin
      index_nxt = `UIF_RST_INDEX; // [R13]
      inEn_nxt[5:0] = `UIF_MASK_IN_FLAGS; // [R13]
      outEn_nxt[5:1] = 5'(`UIF_MASK_OUT_FLAGS >> 1); // [R13]
      comEn_nxt[`UIF_BIT_BUS_RESET] = 1'b1; // [R13]
      comEn_nxt[`UIF_BIT_BUS_RESUME] = 1'b1; // [R13]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      inEn_r <= `UIF_RST_IN_ENABLE; // [R5]
      outEn_r <= 7'(`UIF_RST_OUT_ENABLE >> 1); // [R7]
      comEn_r <= `UIF_RST_COMMON_ENABLE; // [R8]
      index_r <= `UIF_RST_INDEX; // [R12]
    end else begin
      inEn_r <= inEn_nxt;
      outEn_r <= outEn_nxt;
      comEn_r <= comEn_nxt;
      index_r <= index_nxt;
    end
  end

  // ==========================================================
  // read data, frame number and interrupt request
  always_comb begin
    frame_nxt = frameNumber; // [R9] [R10]
    rdata_nxt = 8'h00;
    if (regRead) begin
      unique case (1'b1)
        hit(regAddr, `UIF_ADDR_IN_FLAGS): rdata_nxt = {2'b00, inFlags_r}; // [R1]
        hit(regAddr, `UIF_ADDR_OUT_FLAGS): rdata_nxt = {2'b00, outFlags_r, 1'b0}; // [R3]
        hit(regAddr, `UIF_ADDR_COMMON_FLAGS): rdata_nxt = {4'h0, comFlags_r}; // [R4]
        hit(regAddr, `UIF_ADDR_IN_ENABLE): rdata_nxt = inEn_r;
        hit(regAddr, `UIF_ADDR_OUT_ENABLE): rdata_nxt = {outEn_r, 1'b0};
        hit(regAddr, `UIF_ADDR_COMMON_ENABLE): rdata_nxt = {4'h0, comEn_r};
        hit(regAddr, `UIF_ADDR_FRAME_LOW): rdata_nxt = frame_r[7:0]; // [R9]
        hit(regAddr, `UIF_ADDR_FRAME_HIGH): rdata_nxt = {5'h00, frame_r[10:8]}; // [R10]
        hit(regAddr, `UIF_ADDR_INDEX): rdata_nxt = {4'h0, index_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
    // next values are used so the request lines up with the flag registers
    irq_nxt = |(inFlags_nxt & inEn_nxt[5:0]) | |(outFlags_nxt & outEn_nxt[5:1])
      | |(comFlags_nxt & comEn_nxt); // [R15]
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      frame_r <= 11'h000; // [R9] [R10]
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      frame_r <= frame_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================
  // outputs, each straight from a flip-flop
  assign regRdata = rdata_r;
  assign endpointIndex = index_r; // [R12]
  assign usbIrq = irq_r;
endmodule : uif_interrupt_bank

// file: dv/uif_interrupt_bank_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module uif_interrupt_bank_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire uif_pkg::uif_addr_t regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire uif_pkg::uif_byte_t regWdata,
  input wire uif_pkg::uif_byte_t regRdata,
  // engine side and outputs
  input wire logic [5:0] inEvent,
  input wire logic busResetEvent,
  input wire uif_pkg::uif_frame_t frameNumber,
  input wire uif_pkg::uif_index_t endpointIndex,
  input wire logic usbIrq
);
  import uif_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_inRsv; $past(regRead && regAddr == 16'hde02) |-> regRdata[7:6] == 2'h0; endproperty
  a_inRsv: assert property (p_inRsv) else $error("in flags upper bits set");
  property p_outRsv; $past(regRead && regAddr == 16'hde04) |-> {regRdata[7:6], regRdata[0]} == 3'h0; endproperty
  a_outRsv: assert property (p_outRsv) else $error("out flags unused bits set");
  property p_cmRsv; $past(regRead && regAddr == 16'hde06) |-> regRdata[7:4] == 4'h0; endproperty
  a_cmRsv: assert property (p_cmRsv) else $error("common flags upper bits set");
  property p_frmL; $past(regRead && regAddr == 16'hde0c) |-> regRdata == $past(frameNumber[7:0], 2); endproperty
  a_frmL: assert property (p_frmL) else $error("frame low wrong");
  property p_frmH; $past(regRead && regAddr == 16'hde0d) |-> regRdata == {5'h00, $past(frameNumber[10:8], 2)};
  endproperty
  a_frmH: assert property (p_frmH) else $error("frame high wrong");
  sequence s_twoReads;
    regRead && regAddr == 16'hde02 && inEvent == 6'h00 ##1 inEvent == 6'h00 ##1 regRead && regAddr == 16'hde02;
  endsequence
  property p_clr; s_twoReads |=> regRdata == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("flags kept after read");
  property p_idxRst; busResetEvent |=> endpointIndex == 4'h0; endproperty
  a_idxRst: assert property (p_idxRst) else $error("index kept on bus reset");
  property p_irqRst; busResetEvent |=> usbIrq; endproperty
  a_irqRst: assert property (p_irqRst) else $error("no request on bus reset");
  property p_wIdx; regWrite && regAddr == 16'hde0e && !busResetEvent |=> endpointIndex == $past(regWdata[3:0]); endproperty
  a_wIdx: assert property (p_wIdx) else $error("index write lost");
  c_cmRead: cover property (regRead && regAddr == 16'hde06);
  c_busRst: cover property (busResetEvent);
  c_irqDrop: cover property (usbIrq ##1 !usbIrq);
endmodule : uif_interrupt_bank_monitor
bind uif_interrupt_bank uif_interrupt_bank_monitor u_mon (.mclk(mclk), .rst(rst), .regAddr(regAddr),
  .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .inEvent(inEvent),
  .busResetEvent(busResetEvent), .frameNumber(frameNumber), .endpointIndex(endpointIndex), .usbIrq(usbIrq));

// file: dv/tb_uif_interrupt_bank.sv
`timescale 1ns/1ps
module tb_uif_interrupt_bank;
  import uif_pkg::*;
  // ==========================================================
  // signals and expected state
  logic mclk = 0, rst = 1, regRead = 0, regWrite = 0, frameStartEvent = 0, busResetEvent = 0;
  logic busResumeEvent = 0, busIdle = 0, suspendEnable = 0, usbIrq;
  uif_addr_t regAddr = 16'hde00;
  uif_byte_t regWdata = 8'h00, regRdata, inF = 0, outF = 0, cmF = 0, inE = 8'h3f, outE = 8'h3e, cmE = 8'h06, ix = 0;
  logic [5:0] inEvent = 0;
  logic [5:1] outEvent = 0;
  uif_frame_t frameNumber = 0;
  uif_index_t endpointIndex;
  int failures = 0, checks = 0, seed = 32'hc13e, i, k;
  always #10 mclk = ~mclk;
  uif_interrupt_bank #(.IdleCycles(20)) DUT (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .inEvent(inEvent), .outEvent(outEvent),
    .frameStartEvent(frameStartEvent), .busResetEvent(busResetEvent), .busResumeEvent(busResumeEvent),
    .frameNumber(frameNumber), .busIdle(busIdle), .suspendEnable(suspendEnable),
    .endpointIndex(endpointIndex), .usbIrq(usbIrq));
  // ==========================================================
  // expectations and bus tasks
  function automatic uif_byte_t regExp(uif_addr_t a);
    case (a)
      16'hde02: return inF;
      16'hde04: return outF;
      16'hde06: return cmF;
      16'hde07: return inE;
      16'hde09: return outE;
      16'hde0b: return cmE;
      16'hde0c: return frameNumber[7:0];
      16'hde0d: return {5'h00, frameNumber[10:8]};
      16'hde0e: return ix;
      default: return 8'h00;
    endcase
  endfunction : regExp
  task automatic chk(uif_byte_t got, uif_byte_t exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(uif_addr_t a);
    uif_byte_t e;
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1;
    e = regExp(a);
    @(posedge mclk);
    regRead <= 0;
    #1 chk(regRdata, e);
    if (a == 16'hde02) inF = 0;
    if (a == 16'hde04) outF = 0;
    if (a == 16'hde06) cmF = 0;
  endtask : rd
  task automatic wr(uif_addr_t a, uif_byte_t d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1;
    @(posedge mclk);
    regWrite <= 0;
    if (a == 16'hde07) inE = d;
    if (a == 16'hde09) outE = d & 8'hfe;
    if (a == 16'hde0b) cmE = d & 8'h0f;
    if (a == 16'hde0e) ix = d & 8'h0f;
  endtask : wr
  task automatic ev(logic [5:0] a, logic [4:0] b, logic [2:0] c);
    @(posedge mclk);
    inEvent <= a;
    outEvent <= b;
    {frameStartEvent, busResetEvent, busResumeEvent} <= c;
    @(posedge mclk);
    inEvent <= 0;
    outEvent <= 0;
    {frameStartEvent, busResetEvent, busResumeEvent} <= 0;
    inF |= a;
    outF |= {b, 1'b0};
    cmF |= {c, 1'b0};
    if (c[1]) begin
      {inE[5:0], outE[5:1], cmE[2:1], ix} = {11'h7ff, 2'h3, 8'h00};
    end
    #1 chk({7'h0, usbIrq}, {7'h0, |(inF & inE) | |(outF & outE) | |(cmF & cmE)});
  endtask : ev
  task automatic end_sim();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 0;
    for (k = 0; k < 13; k++) rd(16'(16'hde02 + k));
    chk({4'h0, endpointIndex}, ix);
    // corner: an event in the cycle of the read that clears its flag
    @(posedge mclk);
    regAddr <= 16'hde02;
    regRead <= 1;
    inEvent <= 6'h01;
    @(posedge mclk);
    regRead <= 0;
    inEvent <= 0;
    inF = 8'h01;
    rd(16'hde02);
    for (i = 0; i < 40; i++) begin
      wr(16'hde07, 8'($random(seed) & 8'h3f));
      wr(16'hde09, 8'($random(seed) & 8'h3e));
      wr(16'hde0b, 8'($random(seed) & 8'h0f));
      wr(16'hde0e, 8'({$random(seed)} % 6));
      wr(16'hde05, 8'($random(seed)));
      frameNumber <= 11'($random(seed));
      if (i == 0) ev(6'h3f, 5'h1f, 3'h7);
      else ev(6'($random(seed)), 5'($random(seed)), 3'($random(seed)));
      rd(16'hde02);
      for (k = 0; k < 13; k++) rd(16'(16'hde02 + k));
      chk({7'h0, usbIrq}, 8'h00);
      chk({4'h0, endpointIndex}, ix);
    end
    for (k = 0; k < 2; k++) begin
      @(posedge mclk);
      suspendEnable <= k[0];
      busIdle <= 1;
      repeat (25) @(posedge mclk);
      busIdle <= 0;
      cmF[0] = k[0];
      rd(16'hde06);
    end
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    end_sim();
  end
endmodule : tb_uif_interrupt_bank
